// ===== logic/diag_status_regs.svh
`ifndef DIAG_STATUS_REGS_SVH
`define DIAG_STATUS_REGS_SVH

// Register offsets
`define OFS_FW_TALLY     12'h000
`define OFS_FAULTY       12'h004
`define OFS_PERIOD       12'h008
`define OFS_DIAG_FLAG    12'h00C
`define OFS_GLOBAL       12'h010
`define OFS_LAST_FAULT   12'h014
`define OFS_OVERRUN      12'h018
`define OFS_BUS_LOAD     12'h01C
`define OFS_SVC_TARGET   12'h020
`define DIAG_WIN_TAG     3'h2
`define RST_SVC_TARGET   32'h0000_0000

// Field positions
`define GS_CAN_LSB       16
`define SVC_GROUP_LSB    16

// Service target of the diagnostic area
`define SVC_PORT_DIAG    16'h00C8
`define SVC_GROUP_DIAG   16'hF100

// Codes
`define NODE_DEACTIVATED 8'h01
`define FAULT_BAD_TARGET 8'h01
`define FAULT_NODE_OFF   8'h02
`define WARN_LIMIT       8'h60
`define PCT_FULL         8'h64

// Timing
`define CLK_PERIOD_NS    10
`define UNIT_NS          160
`define UNIT_CYC         (`UNIT_NS / `CLK_PERIOD_NS)
`define BLINK_SLOW_HZ    2
`define BLINK_FAST_HZ    20
`define BLINK_SLOW_CYC   (1_000_000_000 / (2 * `BLINK_SLOW_HZ * `CLK_PERIOD_NS))
`define BLINK_FAST_CYC   (1_000_000_000 / (2 * `BLINK_FAST_HZ * `CLK_PERIOD_NS))
`define LOAD_WIN_MS      100
`define LOAD_WIN_CYC     (`LOAD_WIN_MS * 1_000_000 / `CLK_PERIOD_NS)

`endif

// ===== logic/diag_status_pkg.sv
package diag_status_pkg;

    typedef enum logic [1:0] {
        MODE_RUN     = 2'b00,
        MODE_RESET   = 2'b01,
        MODE_OFFLINE = 2'b10,
        MODE_STOP    = 2'b11
    } card_mode_t;

    typedef enum logic [2:0] {
        LED_DARK     = 3'b000,
        LED_HEALTHY  = 3'b001,
        LED_FAULT    = 3'b010,
        LED_BUS_OFF  = 3'b011,
        LED_RESTART  = 3'b100,
        LED_FAST_ERR = 3'b101
    } led_mode_t;

    typedef struct packed {
        logic [6:0] addr;
        logic [7:0] code;
        logic       cfg;
        logic       dx;
    } station_wr_t;

    typedef struct packed {
        logic busoff;
        logic warn;
    } can_cond_t;

endpackage

// ===== logic/blink_divider.sv
`timescale 1ns/100ps
module blink_divider #(
    parameter int unsigned HALF_CYC = 25_000_000
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // Square wave
    output logic      phase
);
    logic [31:0] cnt_r;
    logic        phase_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r   <= 32'h0000_0000;
            phase_r <= 1'b0;
        end else if (cnt_r == 32'(HALF_CYC - 1)) begin
            cnt_r   <= 32'h0000_0000;
            phase_r <= ~phase_r;
        end else begin
            cnt_r   <= cnt_r + 32'h0000_0001;
        end
    end

    assign phase = phase_r;
endmodule

// ===== logic/station_table.sv
`timescale 1ns/100ps
module station_table (
    // Clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // Firmware updates
    input  wire logic                        wr_valid,
    input  wire diag_status_pkg::station_wr_t wr,
    // Lookup
    input  wire logic [6:0]                  rd_idx,
    output logic [7:0]                       rd_code,
    // Summaries
    output logic [7:0]                       faulty_cnt,
    output logic [7:0]                       missing_cnt,
    output logic                             changed
);
    logic [7:0] code_r [0:127];
    logic       cfg_r  [0:127];
    logic       dx_r   [0:127];
    logic [7:0] faulty_r;
    logic [7:0] missing_r;
    logic       changed_r;
    logic       hit;

    function automatic logic is_bad(input logic cfg, input logic [7:0] code);
        is_bad = cfg && (code != 8'h00);
    endfunction

    function automatic logic is_missing(input logic cfg, input logic dx);
        is_missing = cfg && !dx;
    endfunction

    // Station 0 is the master itself
    assign hit        = wr_valid && (wr.addr != 7'h00);
    assign code_r[0]  = 8'h00;
    assign cfg_r[0]   = 1'b0;
    assign dx_r[0]    = 1'b0;

    for (genvar i = 1; i < 128; i++) begin : g_stn
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                code_r[i] <= 8'h00;
                cfg_r[i]  <= 1'b0;
                dx_r[i]   <= 1'b0;
            end else if (hit && (wr.addr == 7'(i))) begin
                code_r[i] <= wr.code;
                cfg_r[i]  <= wr.cfg;
                dx_r[i]   <= wr.dx;
            end
        end
    end

    // Running counts avoid a 127-way adder tree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faulty_r  <= 8'h00;
            missing_r <= 8'h00;
            changed_r <= 1'b0;
        end else begin
            changed_r <= hit && (wr.code != code_r[wr.addr]);
            if (hit) begin
                faulty_r  <= faulty_r + 8'(is_bad(wr.cfg, wr.code))
                             - 8'(is_bad(cfg_r[wr.addr], code_r[wr.addr]));
                missing_r <= missing_r + 8'(is_missing(wr.cfg, wr.dx))
                             - 8'(is_missing(cfg_r[wr.addr], dx_r[wr.addr]));
            end
        end
    end

    assign rd_code     = code_r[rd_idx];
    assign faulty_cnt  = faulty_r;
    assign missing_cnt = missing_r;
    assign changed     = changed_r;
endmodule

// ===== logic/canopen_master_diag_status.sv
`timescale 1ns/100ps
`include "diag_status_regs.svh"

module canopen_master_diag_status #(
    parameter int unsigned BLINK_SLOW_CYC = `BLINK_SLOW_CYC,
    parameter int unsigned BLINK_FAST_CYC = `BLINK_FAST_CYC,
    parameter int unsigned LOAD_WIN_CYC   = `LOAD_WIN_CYC
) (
    // Clock and reset
    input  wire logic                          CLK_SYS,
    input  wire logic                          RST_N,
    // APB slave
    input  wire logic                          PSEL,
    input  wire logic                          PENABLE,
    input  wire logic                          PWRITE,
    input  wire logic [11:0]                   PADDR,
    input  wire logic [31:0]                   PWDATA,
    output logic                               PREADY,
    output logic [31:0]                        PRDATA,
    output logic                               PSLVERR,
    // Firmware cycle and task
    input  wire logic                          FW_CYCLE_START,
    input  wire logic                          FW_CYCLE_END,
    input  wire logic                          TASK_ACCESS,
    input  wire logic                          TASK_RUNNING,
    // Station status reports
    input  wire logic                          STN_WR_VALID,
    input  wire diag_status_pkg::station_wr_t  STN_WR,
    // Card and CAN controller
    input  wire diag_status_pkg::card_mode_t   CARD_MODE,
    input  wire logic                          RESTART_NEEDED,
    input  wire logic                          CFG_UPLOAD,
    input  wire logic [7:0]                    CAN_TEC,
    input  wire logic [7:0]                    CAN_REC,
    input  wire logic                          CAN_BUSOFF_EV,
    input  wire logic                          CAN_BUS_BUSY,
    // Controls and indicators
    output logic                               CAN_COMM_EN,
    output logic                               LED_ERR,
    output logic                               LED_RUN
);
    localparam int unsigned LOAD_SLOT_CYC = LOAD_WIN_CYC / 100;

    logic [31:0]                  fw_tally_r;
    logic                         cycle_busy_r;
    logic                         overrun_seen_r;
    logic [31:0]                  overrun_r;
    logic [3:0]                   pre_r;
    logic                         unit_tick;
    logic [31:0]                  per_cnt_r;
    logic [31:0]                  period_r;
    logic [7:0]                   faulty_cnt;
    logic [7:0]                   missing_cnt;
    logic [7:0]                   stn_code;
    logic                         stn_changed;
    diag_status_pkg::card_mode_t  mode_r;
    diag_status_pkg::can_cond_t   can_r;
    logic                         comm_en_r;
    logic                         diag_flag_r;
    logic                         diag_evt;
    logic [31:0]                  svc_target_r;
    logic [7:0]                   last_fault_r;
    logic                         pready_r;
    logic [31:0]                  prdata_r;
    logic                         pslverr_r;
    logic                         access;
    logic                         rd_fail;
    logic [7:0]                   fail_code;
    logic [31:0]                  win_cnt_r;
    logic [31:0]                  slot_cnt_r;
    logic [7:0]                   pct_run_r;
    logic [7:0]                   load_pct_r;
    logic                         slow_ph;
    logic                         fast_ph;
    diag_status_pkg::led_mode_t   led_mode;
    logic                         led_err_nxt;
    logic                         led_run_nxt;
    logic                         led_err_r;
    logic                         led_run_r;

    function automatic logic in_diag_window(input logic [11:0] addr);
        in_diag_window = (addr[11:9] == `DIAG_WIN_TAG) && (addr[1:0] == 2'b00);
    endfunction

    station_table u_stations (
        .clk         (CLK_SYS),
        .rst_n       (RST_N),
        .wr_valid    (STN_WR_VALID),
        .wr          (STN_WR),
        .rd_idx      (PADDR[8:2]),
        .rd_code     (stn_code),
        .faulty_cnt  (faulty_cnt),
        .missing_cnt (missing_cnt),
        .changed     (stn_changed)
    );

    blink_divider #(.HALF_CYC(BLINK_SLOW_CYC)) u_blink_slow (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .phase (slow_ph)
    );

    blink_divider #(.HALF_CYC(BLINK_FAST_CYC)) u_blink_fast (
        .clk   (CLK_SYS),
        .rst_n (RST_N),
        .phase (fast_ph)
    );

    // Firmware cycle bookkeeping
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            fw_tally_r     <= 32'h0000_0000;
            cycle_busy_r   <= 1'b0;
            overrun_seen_r <= 1'b0;
            overrun_r      <= 32'h0000_0000;
        end else begin
            if (FW_CYCLE_END) begin
                fw_tally_r <= fw_tally_r + 32'h0000_0001;
            end
            if (FW_CYCLE_START) begin
                cycle_busy_r   <= 1'b1;
                overrun_seen_r <= 1'b0;
            end else if (FW_CYCLE_END) begin
                cycle_busy_r   <= 1'b0;
            end
            // One count per late cycle, however often the task knocks
            if (TASK_ACCESS && cycle_busy_r && !FW_CYCLE_END && !overrun_seen_r) begin
                overrun_r      <= overrun_r + 32'h0000_0001;
                overrun_seen_r <= 1'b1;
            end
        end
    end

    // Cycle period in 160 ns units
    assign unit_tick = (pre_r == 4'(`UNIT_CYC - 1));

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pre_r     <= 4'h0;
            per_cnt_r <= 32'h0000_0000;
            period_r  <= 32'h0000_0000;
        end else begin
            pre_r <= unit_tick ? 4'h0 : pre_r + 4'h1;
            if (FW_CYCLE_END) begin
                per_cnt_r <= 32'h0000_0000;
                if (faulty_cnt == 8'h00 && missing_cnt == 8'h00) begin
                    period_r <= per_cnt_r;
                end
            end else if (unit_tick) begin
                per_cnt_r <= per_cnt_r + 32'h0000_0001;
            end
        end
    end

    // Card state and CAN controller condition
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            mode_r    <= diag_status_pkg::MODE_RESET;
            can_r     <= '0;
            comm_en_r <= 1'b0;
        end else begin
            mode_r     <= CARD_MODE;
            can_r.warn <= (CAN_TEC > `WARN_LIMIT) || (CAN_REC > `WARN_LIMIT);
            // Only a card reset brings the controller back
            if (CAN_BUSOFF_EV) begin
                can_r.busoff <= 1'b1;
            end
            comm_en_r <= !(can_r.busoff || CAN_BUSOFF_EV);
        end
    end

    // Diagnostics-changed flag, set beats a same-cycle clear
    assign diag_evt = stn_changed || (mode_r != CARD_MODE) || (can_r.busoff != (can_r.busoff | CAN_BUSOFF_EV))
                      || (can_r.warn != ((CAN_TEC > `WARN_LIMIT) || (CAN_REC > `WARN_LIMIT)));

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            diag_flag_r <= 1'b0;
        end else if (diag_evt) begin
            diag_flag_r <= 1'b1;
        end else if (access && PWRITE && PADDR == `OFS_DIAG_FLAG && PWDATA[0]) begin
            diag_flag_r <= 1'b0;
        end
    end

    // Bus load: whole percent slots filled within the window
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            win_cnt_r  <= 32'h0000_0000;
            slot_cnt_r <= 32'h0000_0000;
            pct_run_r  <= 8'h00;
            load_pct_r <= 8'h00;
        end else if (win_cnt_r == 32'(LOAD_WIN_CYC - 1)) begin
            win_cnt_r  <= 32'h0000_0000;
            slot_cnt_r <= 32'h0000_0000;
            pct_run_r  <= 8'h00;
            // Last clock of the window still fills a slot, so a busy window reads 100
            load_pct_r <= (pct_run_r > `PCT_FULL) ? `PCT_FULL
                          : pct_run_r + 8'(CAN_BUS_BUSY && slot_cnt_r == 32'(LOAD_SLOT_CYC - 1));
        end else begin
            win_cnt_r <= win_cnt_r + 32'h0000_0001;
            if (CAN_BUS_BUSY) begin
                if (slot_cnt_r == 32'(LOAD_SLOT_CYC - 1)) begin
                    slot_cnt_r <= 32'h0000_0000;
                    pct_run_r  <= pct_run_r + 8'h01;
                end else begin
                    slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
                end
            end
        end
    end

    // APB: one wait state, answer from flops
    assign access = PSEL && PENABLE && !pready_r;
    assign rd_fail = access && !PWRITE && in_diag_window(PADDR)
                     && ((svc_target_r[15:0] != `SVC_PORT_DIAG)
                         || (svc_target_r[31:`SVC_GROUP_LSB] != `SVC_GROUP_DIAG)
                         || (PADDR[8:2] != 7'h00 && stn_code == `NODE_DEACTIVATED));
    assign fail_code = (svc_target_r[15:0] != `SVC_PORT_DIAG)
                       || (svc_target_r[31:`SVC_GROUP_LSB] != `SVC_GROUP_DIAG)
                       ? `FAULT_BAD_TARGET : `FAULT_NODE_OFF;

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= access;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
            if (access && PWRITE) begin
                pslverr_r <= !(PADDR == `OFS_SVC_TARGET || PADDR == `OFS_DIAG_FLAG);
            end else if (access && in_diag_window(PADDR)) begin
                pslverr_r <= rd_fail;
                if (!rd_fail) begin
                    prdata_r <= (PADDR[8:2] == 7'h00) ? {30'h0000_0000, mode_r} : {24'h00_0000, stn_code};
                end
            end else if (access) begin
                case (PADDR)
                    `OFS_FW_TALLY:   prdata_r <= fw_tally_r;
                    `OFS_FAULTY:     prdata_r <= {24'h00_0000, faulty_cnt};
                    `OFS_PERIOD:     prdata_r <= period_r;
                    `OFS_DIAG_FLAG:  prdata_r <= {31'h0000_0000, diag_flag_r};
                    `OFS_GLOBAL:     prdata_r <= {8'h00, 6'h00, can_r, 14'h0000, mode_r};
                    `OFS_LAST_FAULT: prdata_r <= {24'h00_0000, last_fault_r};
                    `OFS_OVERRUN:    prdata_r <= overrun_r;
                    `OFS_BUS_LOAD:   prdata_r <= {24'h00_0000, load_pct_r};
                    `OFS_SVC_TARGET: prdata_r <= svc_target_r;
                    default:         pslverr_r <= 1'b1;
                endcase
            end
        end
    end

    // Service target that software must select before diagnostic reads
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            svc_target_r <= `RST_SVC_TARGET;
            last_fault_r <= 8'h00;
        end else begin
            if (access && PWRITE && PADDR == `OFS_SVC_TARGET) begin
                svc_target_r <= PWDATA;
            end
            if (rd_fail) begin
                last_fault_r <= fail_code;
            end
        end
    end

    // LED pattern selection, most severe first
    always_comb begin
        if (RESTART_NEEDED) begin
            led_mode = diag_status_pkg::LED_RESTART;
        end else if (CFG_UPLOAD || mode_r == diag_status_pkg::MODE_STOP) begin
            led_mode = diag_status_pkg::LED_FAST_ERR;
        end else if (mode_r != diag_status_pkg::MODE_RUN) begin
            led_mode = diag_status_pkg::LED_DARK;
        end else if (can_r.busoff) begin
            led_mode = diag_status_pkg::LED_BUS_OFF;
        end else if (faulty_cnt != 8'h00 || missing_cnt != 8'h00) begin
            led_mode = diag_status_pkg::LED_FAULT;
        end else begin
            led_mode = diag_status_pkg::LED_HEALTHY;
        end
    end

    always_comb begin
        case (led_mode)
            diag_status_pkg::LED_HEALTHY: begin
                led_err_nxt = 1'b0;
                led_run_nxt = TASK_RUNNING ? 1'b1 : slow_ph;
            end
            diag_status_pkg::LED_FAULT: begin
                led_err_nxt = slow_ph;
                led_run_nxt = TASK_RUNNING;
            end
            diag_status_pkg::LED_BUS_OFF: begin
                led_err_nxt = 1'b1;
                led_run_nxt = 1'b0;
            end
            diag_status_pkg::LED_RESTART: begin
                led_err_nxt = fast_ph;
                led_run_nxt = fast_ph;
            end
            diag_status_pkg::LED_FAST_ERR: begin
                led_err_nxt = fast_ph;
                led_run_nxt = 1'b0;
            end
            default: begin
                led_err_nxt = 1'b0;
                led_run_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            led_err_r <= 1'b0;
            led_run_r <= 1'b0;
        end else begin
            led_err_r <= led_err_nxt;
            led_run_r <= led_run_nxt;
        end
    end

    assign PREADY      = pready_r;
    assign PRDATA      = prdata_r;
    assign PSLVERR     = pslverr_r;
    assign CAN_COMM_EN = comm_en_r;
    assign LED_ERR     = led_err_r;
    assign LED_RUN     = led_run_r;

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    a_tally_hold:
    assert property (!FW_CYCLE_END |=> $stable(fw_tally_r)) else $error("tally moved without cycle end");
    a_unit_spacing:
    assert property (unit_tick |=> !unit_tick [*8] ##1 !unit_tick [*7] ##1 unit_tick)
        else $error("unit tick not every 16 clocks");
    a_period_frozen:
    assert property (FW_CYCLE_END && faulty_cnt != 8'h00 |=> $stable(period_r)) else $error("period updated on fault");
    a_flag_set_wins:
    assert property (diag_evt |=> diag_flag_r) else $error("diag flag missed an event");
    a_warn_limit:
    assert property ((CAN_TEC > 8'h60) != can_r.warn && CAN_REC <= 8'h60 |=> can_r.warn == ($past(CAN_TEC) > 8'h60))
        else $error("warning limit wrong");
    a_busoff_sticky:
    assert property (can_r.busoff |=> can_r.busoff && !CAN_COMM_EN) else $error("bus-off left without reset");
    a_fault_capture:
    assert property (rd_fail |=> last_fault_r == $past(fail_code) && PSLVERR && PREADY)
        else $error("failed access not recorded");
    a_overrun_step:
    assert property (TASK_ACCESS && cycle_busy_r && !FW_CYCLE_END && !overrun_seen_r
                     |=> overrun_r == $past(overrun_r) + 32'h0000_0001) else $error("overrun not counted");
    a_led_busoff:
    assert property (led_mode == diag_status_pkg::LED_BUS_OFF |=> LED_ERR && !LED_RUN) else $error("bus-off LEDs wrong");
    a_led_healthy:
    assert property (led_mode == diag_status_pkg::LED_HEALTHY && TASK_RUNNING |=> !LED_ERR && LED_RUN)
        else $error("healthy LEDs wrong");

    c_overrun: cover property (overrun_r != 32'h0000_0000);
    c_busoff:  cover property (can_r.busoff && PREADY);
    c_diag_rd: cover property (access && !PWRITE && in_diag_window(PADDR) && !rd_fail);
    c_period:  cover property (FW_CYCLE_END && faulty_cnt == 8'h00 && missing_cnt == 8'h00);
endmodule

// ===== bench/slave_nodes_model.sv
`timescale 1ns/100ps
module slave_nodes_model (
    // Clock
    input  wire logic                          clk,
    // Report request
    input  wire logic                          send,
    input  wire logic [6:0]                    addr,
    input  wire logic [7:0]                    code,
    // Station report
    output logic                               valid,
    output diag_status_pkg::station_wr_t       wr
);
    // Healthy nodes exchange data, faulty ones drop out
    always_ff @(posedge clk) begin
        valid <= send;
        wr    <= '{addr: addr, code: code, cfg: 1'b1, dx: (code == 8'h00)};
    end
endmodule

// ===== bench/canopen_master_diag_status_tb_top.sv
`timescale 1ns/100ps
`include "diag_status_regs.svh"
module canopen_master_diag_status_tb_top;
    logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, pready, pslverr, st = 0, en = 0, ta = 0, run = 0;
    logic boff = 0, send = 0, valid, comm, lerr, lrun, busy = 0, o;
    logic [11:0] pa = '0;
    logic [31:0] pwd = '0, prdata, q;
    logic [7:0]  tec = '0, rec = '0, code = '0;
    logic [6:0]  addr = '0;
    diag_status_pkg::station_wr_t wr;
    diag_status_pkg::card_mode_t mode = diag_status_pkg::MODE_RUN;
    int bad_count = 0, comparisons = 0;
    always #5 clk = ~clk;
    slave_nodes_model u_nodes (.clk(clk), .send(send), .addr(addr), .code(code), .valid(valid), .wr(wr));
    // Short divider and window values keep the run brief
    canopen_master_diag_status #(.BLINK_SLOW_CYC(8), .BLINK_FAST_CYC(4), .LOAD_WIN_CYC(400)) u_dut (
        .CLK_SYS(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd),
        .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .FW_CYCLE_START(st), .FW_CYCLE_END(en),
        .TASK_ACCESS(ta), .TASK_RUNNING(run), .STN_WR_VALID(valid), .STN_WR(wr),
        .CARD_MODE(mode), .RESTART_NEEDED(1'b0), .CFG_UPLOAD(1'b0), .CAN_TEC(tec),
        .CAN_REC(rec), .CAN_BUSOFF_EV(boff), .CAN_BUS_BUSY(busy), .CAN_COMM_EN(comm), .LED_ERR(lerr),
        .LED_RUN(lrun));
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Request held until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        chk(32'(pslverr), 32'(e));
        psel <= 1'b0; pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
        apb(1'b0, a, '0, e);
        chk(q, x);
    endtask
    // Pulse select: 0 start, 1 end, 2 task access, 3 station report, 4 bus-off
    task automatic pulse(input int s);
        {boff, send, ta, en, st} <= 5'(1 << s);
        @(posedge clk);
        {boff, send, ta, en, st} <= 5'h00;
        @(posedge clk);
    endtask
    task automatic cyc(input int gap);
        pulse(0);
        repeat (gap) @(posedge clk);
        pulse(1);
    endtask
    task automatic stn(input logic [6:0] a, input logic [7:0] c);
        addr <= a; code <= c;
        pulse(3);
        repeat (3) @(posedge clk);
    endtask
    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200_000;
        bad_count++;
        finish_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`OFS_FW_TALLY, '0, 1'b0);
        rd(12'h0FC, '0, 1'b1);
        $display("test reset done");
        pulse(0);
        pulse(2);
        pulse(1);
        cyc(30);
        rd(`OFS_FW_TALLY, 32'h0000_0002, 1'b0);
        rd(`OFS_OVERRUN, 32'h0000_0001, 1'b0);
        rd(`OFS_PERIOD, 32'h0000_0002, 1'b0);
        run <= 1'b1;
        stn(7'h05, 8'h00);
        rd(`OFS_FAULTY, '0, 1'b0);
        chk(32'({lerr, lrun}), 32'h0000_0001);
        apb(1'b1, `OFS_DIAG_FLAG, 32'h0000_0001, 1'b0);
        rd(`OFS_DIAG_FLAG, '0, 1'b0);
        stn(7'h05, 8'h03);
        rd(`OFS_FAULTY, 32'h0000_0001, 1'b0);
        rd(`OFS_DIAG_FLAG, 32'h0000_0001, 1'b0);
        chk(32'(lrun), 32'h0000_0001);
        cyc(60);
        rd(`OFS_PERIOD, 32'h0000_0002, 1'b0);
        $display("test cycles done");
        apb(1'b1, `OFS_SVC_TARGET, 32'hF100_00C8, 1'b0);
        rd(12'h414, 32'h0000_0003, 1'b0);
        rd(12'h400, '0, 1'b0);
        stn(7'h06, `NODE_DEACTIVATED);
        rd(12'h418, '0, 1'b1);
        rd(`OFS_LAST_FAULT, 32'(`FAULT_NODE_OFF), 1'b0);
        apb(1'b1, `OFS_SVC_TARGET, '0, 1'b0);
        rd(12'h414, '0, 1'b1);
        rd(`OFS_LAST_FAULT, 32'(`FAULT_BAD_TARGET), 1'b0);
        $display("test diag area done");
        tec <= 8'h60;
        rd(`OFS_GLOBAL, '0, 1'b0);
        rec <= 8'h61;
        rd(`OFS_GLOBAL, 32'h0001_0000, 1'b0);
        rec <= 8'h00;
        pulse(4);
        rd(`OFS_GLOBAL, 32'h0002_0000, 1'b0);
        chk(32'({comm, lerr, lrun}), 32'h0000_0002);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(32'(comm), 32'h0000_0001);
        $display("test can done");
        run <= 1'b0;
        repeat (2) @(posedge clk);
        o = lrun;
        repeat (8) @(posedge clk);
        chk(32'({lerr, lrun ^ o}), 32'h0000_0001);
        mode <= diag_status_pkg::MODE_STOP;
        rd(`OFS_GLOBAL, 32'h0000_0003, 1'b0);
        o = lerr;
        repeat (4) @(posedge clk);
        chk(32'({lerr ^ o, lrun}), 32'h0000_0002);
        mode <= diag_status_pkg::MODE_RUN;
        busy <= 1'b1;
        repeat (820) @(posedge clk);
        rd(`OFS_BUS_LOAD, 32'h0000_0064, 1'b0);
        busy <= 1'b0;
        repeat (820) @(posedge clk);
        rd(`OFS_BUS_LOAD, '0, 1'b0);
        $display("test leds and load done");
        finish_test;
    end
endmodule
